// [rq_pkg.sv]
// Package for the reading store and error queue block
package rq_pkg;
	// ==========================================================
	// Sizes
	localparam int RDG_DEPTH = 1024;
	localparam int RDG_AW = 10;
	localparam int RDG_W = 32;
	localparam int ERR_DEPTH = 20;
	localparam int ERR_AW = 5;
	localparam int ERR_TXT_MAX = 80;
	localparam int ERR_TXT_W = 7;
	// ==========================================================
	// Codes
	localparam logic signed [15:0] ERR_CODE_OVF = -16'sd350;
	localparam logic signed [15:0] ERR_CODE_NONE = 16'sh0000;
	localparam logic signed [15:0] ERR_CODE_TEST = -16'sd330;
	// ==========================================================
	// Self-test timing
	localparam int CLK_HZ = 10000000;
	localparam int TEST_SEC = 15;
	localparam longint TEST_CYCLES_L = longint'(TEST_SEC) * CLK_HZ;
	localparam logic [31:0] TEST_CYCLES = TEST_CYCLES_L[31:0];
	localparam logic [RDG_AW:0] CNT_ZERO = '0;
	localparam logic [RDG_AW:0] RDG_FULL = 11'h400;
	localparam logic [ERR_AW:0] ERR_FULL = 6'h14;

	typedef struct packed {
		logic signed [15:0] code;
		logic [ERR_TXT_W-1:0] text_len;
	} rq_err_s;

	typedef enum logic [1:0] {
		RQ_IDLE,
		RQ_TEST,
		RQ_STORE
	} rq_test_e;
endpackage : rq_pkg

// [rq_queues.sv]
// Reading store and error queue for a precision meter
`timescale 1ns/1ns
// Contract
// - Store 1024 readings, return oldest first
// - Clear store on enable, reset, self-test
// - Store sample-count readings per trigger; the code has no trigger and stores one reading per rdg_valid_i cycle
// - Entries hold reading value only
// - Recall menu switches storage off
// - Report stored reading count
// - Twenty-record error queue, indicator while pending
// - Errors oldest first, indicator off when empty
// - One beep pulse per cycle with an error push or self-test failure
// - Overflow writes -350 in newest slot
// - Empty read returns code zero
// - Clear errors on reset and clear-status
// - Clear errors on error menu exit
// - Record: signed code plus text length
// - Self-test clears store, stores result
// - Test result 0 pass, 1 fail
// - Self-test runs about fifteen seconds
module rq_queues #(
	parameter logic [31:0] TEST_LEN = rq_pkg::TEST_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic if_reset_i,
	input wire logic store_on_i,
	input wire logic store_off_i,
	input wire logic reading_store_enable_menu_i,
	input wire logic stored_reading_recall_menu_i,
	input wire logic rdg_valid_i,
	input wire logic [rq_pkg::RDG_W-1:0] rdg_data_i,
	input wire logic rdg_pop_i,
	input wire logic err_push_i,
	input wire rq_pkg::rq_err_s err_i,
	input wire logic err_pop_i,
	input wire logic clear_status_i,
	input wire logic err_menu_param_i,
	input wire logic menu_exit_i,
	input wire logic test_start_i,
	input wire logic test_fail_i,
	output logic store_en_o,
	output logic [rq_pkg::RDG_W-1:0] rdg_data_o,
	output logic rdg_data_valid_o,
	output logic [rq_pkg::RDG_AW:0] rdg_count_o,
	output rq_pkg::rq_err_s err_o,
	output logic err_valid_o,
	output logic err_ind_o,
	output logic [rq_pkg::ERR_AW:0] err_count_o,
	output logic beep_o,
	output logic test_busy_o,
	output logic test_done_o,
	output logic test_result_o
);
	import rq_pkg::*;

	// ==========================================================
	// Reading store
	logic [RDG_W-1:0] rdg_mem [RDG_DEPTH];
	logic [RDG_AW-1:0] rd_wp_reg;
	logic [RDG_AW-1:0] rd_rp_reg;
	logic [RDG_AW:0] rd_cnt_reg;
	logic store_en_reg;
	rq_test_e test_reg;
	logic [31:0] test_cnt_reg;
	logic test_fail_reg;

	// Storage off from recall menu wins over enable in same cycle
	wire logic turn_on = store_on_i | reading_store_enable_menu_i;
	wire logic turn_off = store_off_i | stored_reading_recall_menu_i;
	wire logic store_clr = if_reset_i | (turn_on & ~store_en_reg)
		| (test_start_i & test_reg == RQ_IDLE);
	wire logic rd_empty = rd_cnt_reg == CNT_ZERO;
	wire logic rd_full = rd_cnt_reg == RDG_FULL;
	// Test result word goes in regardless of the enable
	wire logic test_wr = test_reg == RQ_STORE;
	// A delivered sample is stored only while enabled, no self-test runs and the store is not full
	wire logic rd_push = ((rdg_valid_i & store_en_reg & test_reg == RQ_IDLE)
		| test_wr) & ~rd_full;
	// Pops are never held off; kept as a named hook for a later arbiter
	wire logic rd_push_blocked = 1'b0;
	wire logic rd_pop = rdg_pop_i & ~rd_empty & ~rd_push_blocked;
	wire logic [RDG_W-1:0] rd_wdata = test_wr ?
		{{(RDG_W-1){1'b0}}, test_fail_reg} : rdg_data_i;

	// Store enable state, cleared on interface reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || if_reset_i)
			store_en_reg <= 1'b0;
		else if (turn_off)
			store_en_reg <= 1'b0;
		else if (turn_on)
			store_en_reg <= 1'b1;
	end

	// Memory write; array has no reset
	always_ff @(posedge clk_i) begin
		if (rd_push)
			rdg_mem[rd_wp_reg] <= rd_wdata;
	end

	// Pointers and count; clear wins over traffic
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || store_clr) begin
			rd_wp_reg <= '0;
			rd_rp_reg <= '0;
			rd_cnt_reg <= '0;
		end else begin
			if (rd_push)
				rd_wp_reg <= rd_wp_reg + 1'b1;
			if (rd_pop)
				rd_rp_reg <= rd_rp_reg + 1'b1;
			if (rd_push & ~rd_pop)
				rd_cnt_reg <= rd_cnt_reg + 1'b1;
			else if (rd_pop & ~rd_push)
				rd_cnt_reg <= rd_cnt_reg - 1'b1;
		end
	end

	// Read data, oldest first
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdg_data_o <= '0;
			rdg_data_valid_o <= 1'b0;
		end else begin
			rdg_data_valid_o <= rd_pop & ~store_clr;
			if (rd_pop)
				rdg_data_o <= rdg_mem[rd_rp_reg];
		end
	end

	// ==========================================================
	// Self-test sequencer
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			test_reg <= RQ_IDLE;
			test_cnt_reg <= '0;
			test_fail_reg <= 1'b0;
		end else begin
			case (test_reg)
			RQ_IDLE: begin
				if (test_start_i) begin
					test_reg <= RQ_TEST;
					test_cnt_reg <= '0;
					test_fail_reg <= 1'b0;
				end
			end
			RQ_TEST: begin
				if (test_fail_i)
					test_fail_reg <= 1'b1;
				if (test_cnt_reg >= TEST_LEN - 32'h1)
					test_reg <= RQ_STORE;
				else
					test_cnt_reg <= test_cnt_reg + 32'h1;
			end
			RQ_STORE: test_reg <= RQ_IDLE;
			default: test_reg <= RQ_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Error queue
	rq_err_s err_mem [ERR_DEPTH];
	logic [ERR_AW-1:0] er_wp_reg;
	logic [ERR_AW-1:0] er_rp_reg;
	logic [ERR_AW:0] er_cnt_reg;
	logic er_menu_reg;

	function automatic logic [ERR_AW-1:0] err_inc(
		input logic [ERR_AW-1:0] p
	);
		err_inc = (p == ERR_AW'(ERR_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : err_inc

	function automatic logic [ERR_AW-1:0] err_dec(
		input logic [ERR_AW-1:0] p
	);
		err_dec = (p == '0) ? ERR_AW'(ERR_DEPTH - 1) : p - 1'b1;
	endfunction : err_dec

	// Self-test failure is itself an error event
	wire logic fail_evt = test_wr & test_fail_reg;
	wire logic er_evt = err_push_i | fail_evt;
	wire rq_err_s er_new = err_push_i ? err_i :
		'{code: ERR_CODE_TEST, text_len: '0};
	wire logic er_clr = clear_status_i | (er_menu_reg & menu_exit_i);
	wire logic er_empty = er_cnt_reg == '0;
	wire logic er_full = er_cnt_reg == ERR_FULL;
	wire logic er_pop = err_pop_i;
	wire logic er_pop_real = er_pop & ~er_empty;
	// Full queue: newest slot becomes overflow, only if not yet marked
	wire logic er_ovf_mark = er_evt & er_full & ~er_pop_real &
		(err_mem[err_dec(er_wp_reg)].code != ERR_CODE_OVF);
	wire logic er_push = er_evt & (~er_full | er_pop_real);
	wire logic [ERR_AW-1:0] er_waddr = er_ovf_mark ?
		err_dec(er_wp_reg) : er_wp_reg;
	wire rq_err_s er_wdata = er_ovf_mark ?
		'{code: ERR_CODE_OVF, text_len: ERR_TXT_W'(14)} : er_new;

	// Menu parameter level seen, cleared on menu exit
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || menu_exit_i)
			er_menu_reg <= 1'b0;
		else if (err_menu_param_i)
			er_menu_reg <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (er_push | er_ovf_mark)
			err_mem[er_waddr] <= er_wdata;
	end

	// Pointers; clear loses to nothing since queue restarts empty
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || er_clr) begin
			er_wp_reg <= '0;
			er_rp_reg <= '0;
			er_cnt_reg <= '0;
		end else begin
			if (er_push)
				er_wp_reg <= err_inc(er_wp_reg);
			if (er_pop_real)
				er_rp_reg <= err_inc(er_rp_reg);
			if (er_push & ~er_pop_real)
				er_cnt_reg <= er_cnt_reg + 1'b1;
			else if (er_pop_real & ~er_push)
				er_cnt_reg <= er_cnt_reg - 1'b1;
		end
	end

	// Error answer, no-error when empty
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			err_o <= '{code: ERR_CODE_NONE, text_len: '0};
			err_valid_o <= 1'b0;
		end else begin
			err_valid_o <= er_pop;
			if (er_pop)
				err_o <= er_empty ?
					'{code: ERR_CODE_NONE, text_len: ERR_TXT_W'(8)} :
					err_mem[er_rp_reg];
		end
	end

	// ==========================================================
	// Registered status outputs
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			store_en_o <= 1'b0;
			rdg_count_o <= '0;
			err_ind_o <= 1'b0;
			err_count_o <= '0;
			beep_o <= 1'b0;
			test_busy_o <= 1'b0;
			test_done_o <= 1'b0;
			test_result_o <= 1'b0;
		end else begin
			store_en_o <= store_en_reg;
			rdg_count_o <= rd_cnt_reg;
			err_ind_o <= ~er_empty;
			err_count_o <= er_cnt_reg;
			beep_o <= er_evt;
			test_busy_o <= test_reg != RQ_IDLE;
			test_done_o <= test_wr;
			if (test_wr)
				test_result_o <= test_fail_reg;
		end
	end
endmodule : rq_queues

// [rq_unused.sv]
// Spare unit kept empty, holds no logic
`timescale 1ns/1ns

// [rq_queues_sva.sv]
// Checker for the reading store and error queue ports
`timescale 1ns/1ns
module rq_queues_sva (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic if_reset_i,
	input wire logic rdg_pop_i,
	input wire logic err_push_i,
	input wire logic err_pop_i,
	input wire logic clear_status_i,
	input wire logic store_en_o,
	input wire logic rdg_data_valid_o,
	input wire logic [10:0] rdg_count_o,
	input wire logic err_valid_o,
	input wire logic [5:0] err_count_o,
	input wire logic beep_o,
	input wire logic test_busy_o,
	input wire logic test_done_o
);
	// ==========================================================
	// Port checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Counts and enable show a clear two cycles later
	sequence s_err_gone;
		##2 err_count_o == 6'h00;
	endsequence
	sequence s_rdg_gone;
		##1 (!store_en_o && rdg_count_o == 11'h000);
	endsequence
	rdg_cap_a: assert property (rdg_count_o <= 11'h400)
		else $error("reading count over capacity");
	err_cap_a: assert property (err_count_o <= 6'h14)
		else $error("error count over capacity");
	beep_each_a: assert property (err_push_i |=> beep_o)
		else $error("no beep after error");
	err_answer_a: assert property (err_pop_i |=> err_valid_o)
		else $error("error read not answered");
	err_cause_a: assert property (err_valid_o |-> $past(err_pop_i))
		else $error("error record without read");
	rdg_cause_a: assert property (rdg_data_valid_o |-> $past(rdg_pop_i))
		else $error("reading without read");
	cls_clear_a: assert property (clear_status_i |-> s_err_gone)
		else $error("error queue not cleared");
	ifr_clear_a: assert property (if_reset_i |=> s_rdg_gone)
		else $error("store not cleared on reset");
	test_long_a: assert property ($rose(test_busy_o) |-> !test_done_o [*8])
		else $error("self-test ended too soon");
endmodule : rq_queues_sva

// [rq_host.sv]
// Remote host model that reads back stored readings
`timescale 1ns/1ns
module rq_host (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [3:0] gap_i,
	output logic pop_o
);
	logic [3:0] wait_reg;
	// Gap sets a prompt or slow reader
	initial begin
		pop_o = 1'b0;
		wait_reg = 4'h0;
	end
	always @(negedge clk_i) begin
		pop_o <= go_i && wait_reg == 4'h0;
		wait_reg <= (wait_reg == 4'h0) ? gap_i : wait_reg - 4'h1;
	end
endmodule : rq_host

// [tb.sv]
// Testbench for the reading store and error queue
`timescale 1ns/1ns
module tb;
	import rq_pkg::*;
	logic clk_i, rst_n_i, go, pop, tf, sen, rv, ev, ind, bp, bz, dn, res;
	logic [11:0] p;
	logic [31:0] d, ro;
	logic [15:0] lf;
	logic [10:0] rc;
	logic [5:0] ec;
	logic [3:0] gap;
	rq_err_s ei, eo;
	logic [31:0] rq[$], xq[$];
	logic [15:0] eq[$];
	int err_count, n_tests, nb, i;
	rq_host u_host (.clk_i(clk_i), .go_i(go), .gap_i(gap), .pop_o(pop));
	rq_queues #(.TEST_LEN(32'h14)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.if_reset_i(p[0]), .store_on_i(p[1]), .store_off_i(p[2]),
		.reading_store_enable_menu_i(p[3]),
		.stored_reading_recall_menu_i(p[4]), .rdg_valid_i(p[5]),
		.rdg_data_i(d), .rdg_pop_i(pop), .err_push_i(p[6]), .err_i(ei),
		.err_pop_i(p[7]), .clear_status_i(p[8]), .err_menu_param_i(p[9]),
		.menu_exit_i(p[10]), .test_start_i(p[11]), .test_fail_i(tf),
		.store_en_o(sen), .rdg_data_o(ro), .rdg_data_valid_o(rv),
		.rdg_count_o(rc), .err_o(eo), .err_valid_o(ev), .err_ind_o(ind),
		.err_count_o(ec), .beep_o(bp), .test_busy_o(bz), .test_done_o(dn),
		.test_result_o(res));
	// ==========================================================
	// Clock and collectors
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Answers stand one cycle; look mid-cycle where they are settled
	always @(negedge clk_i) begin
		if (rv === 1'b1) rq.push_back(ro);
		if (ev === 1'b1) eq.push_back(eo.code);
		if (bp === 1'b1) nb++;
	end
	// ==========================================================
	// Tasks
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic pulse(input int b);
		@(negedge clk_i);
		p[b] = 1'b1;
		@(negedge clk_i);
		p = '0;
	endtask : pulse
	// Counts lag two cycles, four is safe
	task automatic rest;
		repeat (4) @(negedge clk_i);
	endtask : rest
	task automatic drain(input int n);
		go = 1'b1;
		for (int k = 0; k < 4000 && rq.size() < n; k++) @(negedge clk_i);
		go = 1'b0;
		rest();
	endtask : drain
	task automatic wait_done;
		for (int k = 0; k < 100 && dn !== 1'b1; k++) @(negedge clk_i);
	endtask : wait_done
	task automatic wrap_up;
		if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// Watchdog at 10000 cycles, well past the expected run of about 2300 cycles
	initial begin
		#1000000;
		err_count++;
		wrap_up();
	end
	// ==========================================================
	// Scenarios
	initial begin
		rst_n_i = 1'b0;
		p = '0;
		d = '0;
		ei = '0;
		tf = 1'b0;
		go = 1'b0;
		gap = 4'h3;
		lf = 16'hABF0;
		err_count = 0;
		n_tests = 0;
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'b1;
		// Slow host reads random readings in order
		pulse(1);
		repeat (6) begin
			lf = nx(lf);
			d = {lf, ~lf};
			xq.push_back(d);
			pulse(5);
		end
		rest();
		chk(rc, 32'h6);
		drain(6);
		foreach (xq[k]) chk(rq[k], xq[k]);
		chk(rc, 32'h0);
		rq.delete();
		// Overfill back to back, then drain at full rate
		gap = 4'h0;
		p[5] = 1'b1;
		for (i = 0; i < 1030; i++) begin
			d = 32'(i);
			@(negedge clk_i);
		end
		p = '0;
		rest();
		chk(rc, 32'h400);
		drain(1024);
		chk(rq[1023], 32'h3FF);
		rq.delete();
		// Interface reset, menu keys, re-enable
		pulse(5);
		pulse(0);
		rest();
		chk(rc, 32'h0);
		chk(sen, 1'h0);
		pulse(3);
		pulse(5);
		pulse(4);
		pulse(5);
		rest();
		chk(sen, 1'h0);
		chk(rc, 32'h1);
		pulse(1);
		rest();
		chk(rc, 32'h0);
		// Self-test fail then pass
		pulse(5);
		tf = 1'b1;
		pulse(11);
		@(negedge clk_i);
		chk(bz, 1'h1);
		wait_done();
		chk(res, 1'h1);
		rest();
		chk(ind, 1'h1);
		chk(rc, 32'h1);
		tf = 1'b0;
		pulse(11);
		wait_done();
		chk(res, 1'h0);
		// Error queue overflow and empty read
		pulse(8);
		rest();
		chk(ec, 32'h0);
		nb = 0;
		xq.delete();
		repeat (22) begin
			lf = nx(lf);
			ei.code = lf;
			xq.push_back({16'h0000, lf});
			pulse(6);
		end
		rest();
		chk(ec, 32'h14);
		chk(ind, 1'h1);
		chk(nb, 32'h16);
		eq.delete();
		repeat (21) pulse(7);
		rest();
		for (i = 0; i < 19; i++) chk(eq[i], xq[i]);
		chk(eq[19], unsigned'(ERR_CODE_OVF));
		chk(eq[20], 32'h0);
		chk(ind, 1'h0);
		// Error menu visit empties the queue
		pulse(6);
		pulse(9);
		pulse(10);
		rest();
		chk(ec, 32'h0);
		wrap_up();
	end
endmodule : tb
bind rq_queues rq_queues_sva u_sva (.*);
